// >>> rtl/fmc_pkg.sv
// Package: flash mode control constants, register map and types
package fmc_pkg;

    // Register addresses on the internal bus
    localparam logic [15:0] FMC_ADDR_MODE_CTRL = 16'hff80;
    localparam logic [15:0] FMC_ADDR_LARGE_SEL = 16'hff82;
    localparam logic [15:0] FMC_ADDR_SMALL_SEL = 16'hff83;
    localparam logic [15:0] FMC_ADDR_WAIT_OVL = 16'hffc2;

    // Register window that moves with the supply and mode
    localparam logic [15:0] FMC_CTRL_LO = 16'hff80;
    localparam logic [15:0] FMC_CTRL_HI = 16'hff83;

    // Flash array top address per mode
    localparam logic [15:0] FMC_TOP_MODE2 = 16'hef7f;
    localparam logic [15:0] FMC_TOP_MODE3 = 16'hf77f;

    // Reset and fixed read values
    localparam logic [7:0] FMC_RST_MODE_CTRL = 8'h00;
    localparam logic [7:0] FMC_RST_MODE_CTRL_VPP = 8'h80;
    localparam logic [7:0] FMC_RST_BLOCK_SEL = 8'h00;
    localparam logic [7:0] FMC_RST_WAIT_OVL = 8'h08;
    localparam logic [7:0] FMC_READ_RESERVED = 8'hff;

    // Mode-control field positions
    localparam int FMC_BIT_VPP = 7;
    localparam int FMC_BIT_ERASE_VERIFY = 3;
    localparam int FMC_BIT_PROG_VERIFY = 2;
    localparam int FMC_BIT_ERASE = 1;
    localparam int FMC_BIT_PROG = 0;
    localparam logic [7:0] FMC_MODE_CTRL_WMASK = 8'h0f;

    // Overlay control field positions
    localparam int FMC_BIT_OVL_HIGH = 7;
    localparam int FMC_BIT_OVL_LOW = 6;

    // Flash read takes two bus states
    localparam int FMC_READ_STATES = 2;

    // Operating mode from the two mode pins
    typedef enum logic [1:0] {
        FMC_MODE_ILLEGAL,
        FMC_MODE_EXTERNAL,
        FMC_MODE_ROM2,
        FMC_MODE_ROM3
    } fmc_mode_t;

endpackage

// >>> rtl/fmc_flash_port.sv
// Flash array read port: two-state read of the 16-bit array
`timescale 1ns/10ps
`default_nettype none
module fmc_flash_port
#(
    parameter int AW = 15
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Request from the decoder
    input wire logic req,
    input wire logic [AW-1:0] word_addr,
    // Array side
    output logic [AW-1:0] arr_addr,
    output logic arr_en,
    input wire logic [15:0] arr_data,
    // Answer
    output logic done,
    output logic [15:0] rdata
);
    import fmc_pkg::*;

    typedef enum logic [1:0] {FP_IDLE, FP_T1, FP_T2} fmc_fp_state_t;

    fmc_fp_state_t state_q;

    // Word address must fit the 16-bit byte address space
    if (AW < 1 || AW > 15)
    begin : g_bad_aw
        $error("fmc_flash_port: AW out of range");
    end

    // Two states per access, byte or word alike
    always_ff @(posedge clk)
    begin
        if (srst)
            state_q <= FP_IDLE;
        else
            case (state_q)
                FP_IDLE: if (req) state_q <= FP_T1;
                FP_T1: state_q <= FP_T2;
                FP_T2: state_q <= req ? FP_T1 : FP_IDLE;
                default: state_q <= FP_IDLE;
            endcase
    end

    // Address held for the whole access
    always_ff @(posedge clk)
    begin
        if (srst)
            arr_addr <= '0;
        else if (req && state_q != FP_T1)
            arr_addr <= word_addr;
    end

    // Read data registered in the first state, held in the second
    always_ff @(posedge clk)
    begin
        if (srst)
            rdata <= 16'h0000;
        else if (state_q == FP_T1)
            rdata <= arr_data;
    end

    assign arr_en = (state_q == FP_T1);
    assign done = (state_q == FP_T2);
endmodule
`default_nettype wire

// >>> rtl/fmc_top.sv
// Flash mode control: mode decode, address map and control registers
`timescale 1ns/10ps
`default_nettype none
module fmc_top
#(
    parameter int FLASH_AW = 15
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    input wire logic STANDBY,
    // Mode pins and supply detector
    input wire logic MODE_PIN_HIGH,
    input wire logic MODE_PIN_LOW,
    input wire logic PROGRAMMING_SUPPLY_INPUT,
    // Internal CPU bus
    input wire logic BUS_REQ,
    input wire logic BUS_WR,
    input wire logic BUS_BYTE,
    input wire logic [15:0] BUS_ADDR,
    input wire logic [15:0] BUS_WDATA,
    output logic [15:0] BUS_RDATA,
    output logic BUS_ACK,
    output logic BUS_EXTERNAL,
    // Flash array
    output logic [FLASH_AW-1:0] ARRAY_ADDR,
    output logic ARRAY_EN,
    input wire logic [15:0] ARRAY_DATA,
    // Flash operation controls
    output logic PROGRAM_EN,
    output logic ERASE_EN,
    output logic PROGRAM_VERIFY_EN,
    output logic ERASE_VERIFY_EN,
    output logic [7:0] LARGE_BLOCK_EN,
    output logic [7:0] SMALL_BLOCK_EN,
    output logic RAM_OVERLAY_ACTIVE,
    output fmc_pkg::fmc_mode_t OPERATING_MODE,
    output logic MODE_ILLEGAL,
    // Boot serial channel pins
    input wire logic BOOT_SERIAL_IN,
    output logic BOOT_SERIAL_OUT,
    input wire logic BOOT_TX_DATA,
    output logic BOOT_RX_DATA
);
    import fmc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    // Stored registers
    logic [3:0] mode_sel_q;
    logic [7:0] large_sel_q;
    logic [7:0] small_sel_q;
    logic [7:0] wait_ovl_q;

    // Read path and answers
    logic [7:0] mode_ctrl_rd;
    logic [7:0] reg_rd_byte;
    logic [15:0] reg_rdata_q;
    logic reg_ack_q;
    logic ext_ack_q;

    // Mode, map and window decode
    logic rom_on;
    logic vpp;
    logic in_ctrl_win;
    logic ctrl_live;
    logic ctrl_reserved;
    logic ctrl_external;
    logic hit_flash;
    logic hit_wait_ovl;
    logic overlay_one;
    logic reg_cycle;
    logic new_access;
    fmc_mode_t mode;

    // Write strobes
    logic wr_mode_ctrl;
    logic wr_large_sel;
    logic wr_small_sel;
    logic wr_wait_ovl;

    // Flash port
    logic flash_req;
    logic flash_done;
    logic [15:0] flash_rdata;

    // Array width is fixed by the 60-kbyte map; refuse anything else
    if (FLASH_AW != 15)
    begin : g_bad_aw
        $error("fmc_top: flash array must be 15 word address bits");
    end

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Mode pins to operating mode; used for the map and the status port
    function automatic fmc_mode_t decode_mode(input logic hi, input logic lo);
        case ({hi, lo})
            2'b00: decode_mode = FMC_MODE_ILLEGAL;
            2'b01: decode_mode = FMC_MODE_EXTERNAL;
            2'b10: decode_mode = FMC_MODE_ROM2;
            2'b11: decode_mode = FMC_MODE_ROM3;
            default: decode_mode = FMC_MODE_ILLEGAL;
        endcase
    endfunction

    // Flash array range for a mode
    function automatic logic in_flash(input fmc_mode_t m,
                                      input logic [15:0] a);
        case (m)
            FMC_MODE_ROM2: in_flash = (a <= FMC_TOP_MODE2);
            FMC_MODE_ROM3: in_flash = (a <= FMC_TOP_MODE3);
            default: in_flash = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Mode and map decode
    // ------------------------------------------------------------

    // Mode and supply taken as steady synchronous levels
    assign mode = decode_mode(MODE_PIN_HIGH, MODE_PIN_LOW);
    assign vpp = PROGRAMMING_SUPPLY_INPUT;
    assign rom_on = (mode == FMC_MODE_ROM2) || (mode == FMC_MODE_ROM3);
    assign OPERATING_MODE = mode;
    assign MODE_ILLEGAL = (mode == FMC_MODE_ILLEGAL);

    // Control window placement per mode and supply
    assign in_ctrl_win = (BUS_ADDR >= FMC_CTRL_LO) &&
                         (BUS_ADDR <= FMC_CTRL_HI);
    assign ctrl_live = in_ctrl_win && rom_on && vpp;
    assign ctrl_reserved = in_ctrl_win &&
        ((mode == FMC_MODE_EXTERNAL && vpp) ||
         (mode == FMC_MODE_ROM3 && !vpp));
    // Mode 2 without supply, or mode 1 without supply, goes off chip
    assign ctrl_external = in_ctrl_win && !ctrl_live && !ctrl_reserved;
    assign hit_wait_ovl = (BUS_ADDR == FMC_ADDR_WAIT_OVL);
    assign hit_flash = in_flash(mode, BUS_ADDR);

    assign reg_cycle = BUS_REQ && !hit_flash && !ctrl_external &&
                       (in_ctrl_win || hit_wait_ovl);
    assign flash_req = new_access && hit_flash && !BUS_WR;

    // The master holds its request through the edge that samples the
    // acknowledge; that edge must not open a second access.
    assign new_access = BUS_REQ && !BUS_ACK;

    // Everything that is neither flash nor a local register leaves chip
    assign BUS_EXTERNAL = BUS_REQ && !hit_flash && !reg_cycle;

    // ------------------------------------------------------------
    // Flash read path
    // ------------------------------------------------------------

    // Word address only: a byte read fetches the whole word and the
    // processor picks its lane, so both sizes take the same two states
    fmc_flash_port #(.AW(FLASH_AW)) u_flash_port (
        .clk(CLK),
        .srst(SRST),
        .req(flash_req),
        .word_addr(BUS_ADDR[15:1]),
        .arr_addr(ARRAY_ADDR),
        .arr_en(ARRAY_EN),
        .arr_data(ARRAY_DATA),
        .done(flash_done),
        .rdata(flash_rdata)
    );

    // ------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------

    // Supply-gated strobes need the live window; a refused window
    // swallows the write but still answers it.
    assign wr_mode_ctrl = new_access && BUS_WR && ctrl_live &&
                          BUS_ADDR == FMC_ADDR_MODE_CTRL;
    assign wr_large_sel = new_access && BUS_WR && ctrl_live &&
                          BUS_ADDR == FMC_ADDR_LARGE_SEL;
    // A word write at the even address carries the odd byte too
    assign wr_small_sel = new_access && BUS_WR && ctrl_live &&
                          BUS_ADDR[15:1] == FMC_ADDR_LARGE_SEL[15:1] &&
                          (BUS_ADDR[0] || !BUS_BYTE);
    // Not supply-gated: overlay and wait states serve normal runs too
    assign wr_wait_ovl = new_access && BUS_WR && hit_wait_ovl;

    // ------------------------------------------------------------
    // Mode-control register
    // ------------------------------------------------------------

    // Only the four select bits are stored; bit 7 is the live supply
    // status and 6..4 are not stored at all, so they cannot drift.
    always_ff @(posedge CLK)
    begin
        if (SRST || STANDBY || !vpp)
            mode_sel_q <= FMC_RST_MODE_CTRL[3:0];
        else if (wr_mode_ctrl)
            mode_sel_q <= BUS_WDATA[11:8] & FMC_MODE_CTRL_WMASK[3:0];
    end

    // Read image: status bit, zero reserved bits, select bits
    assign mode_ctrl_rd = {vpp, 3'b000, mode_sel_q};

    // ------------------------------------------------------------
    // Block-select registers
    // ------------------------------------------------------------

    // Even address takes the upper bus byte, odd the lower one
    always_ff @(posedge CLK)
    begin
        if (SRST || STANDBY || !vpp)
            large_sel_q <= FMC_RST_BLOCK_SEL;
        else if (wr_large_sel)
            large_sel_q <= BUS_WDATA[15:8];
    end

    always_ff @(posedge CLK)
    begin
        if (SRST || STANDBY || !vpp)
            small_sel_q <= FMC_RST_BLOCK_SEL;
        else if (wr_small_sel)
            small_sel_q <= BUS_WDATA[7:0];
    end

    // ------------------------------------------------------------
    // Wait and overlay control
    // ------------------------------------------------------------

    // Kept through software standby; only reset clears it.
    // Hardware standby reaches this block as SRST.
    always_ff @(posedge CLK)
    begin
        if (SRST)
            wait_ovl_q <= FMC_RST_WAIT_OVL;
        else if (wr_wait_ovl)
            wait_ovl_q <= BUS_WDATA[15:8];
    end

    assign overlay_one = wait_ovl_q[FMC_BIT_OVL_HIGH] ^
                         wait_ovl_q[FMC_BIT_OVL_LOW];
    assign RAM_OVERLAY_ACTIVE = overlay_one;

    // ------------------------------------------------------------
    // Register read and answers
    // ------------------------------------------------------------

    // Read mux; reserved locations read all ones, so software tells
    // a missing supply from bits 6..4, since bit 7 reads one either way
    always_comb
    begin
        reg_rd_byte = FMC_READ_RESERVED;
        if (hit_wait_ovl)
            reg_rd_byte = wait_ovl_q;
        else if (ctrl_live)
            case (BUS_ADDR)
                FMC_ADDR_MODE_CTRL: reg_rd_byte = mode_ctrl_rd;
                FMC_ADDR_LARGE_SEL: reg_rd_byte = large_sel_q;
                FMC_ADDR_SMALL_SEL: reg_rd_byte = small_sel_q;
                default: reg_rd_byte = 8'h00;
            endcase
    end

    // Byte placed on both lanes, whatever address bit 0 is
    always_ff @(posedge CLK)
    begin
        if (SRST)
            reg_rdata_q <= 16'h0000;
        else if (reg_cycle && !BUS_WR && !BUS_ACK)
            reg_rdata_q <= {reg_rd_byte, reg_rd_byte};
    end

    // Registers and ignored writes answer one cycle later; a request
    // still held in its acknowledge cycle is not answered twice
    always_ff @(posedge CLK)
    begin
        if (SRST)
            reg_ack_q <= 1'b0;
        else
            reg_ack_q <= reg_cycle && !BUS_ACK;
    end

    // Flash writes are dropped in every mode, program mode too, but answered,
    // so the master never waits on a write it cannot make
    always_ff @(posedge CLK)
    begin
        if (SRST)
            ext_ack_q <= 1'b0;
        else
            ext_ack_q <= new_access && hit_flash && BUS_WR;
    end

    // Flash data wins only while its acknowledge stands
    assign BUS_ACK = reg_ack_q || ext_ack_q || flash_done;
    assign BUS_RDATA = flash_done ? flash_rdata : reg_rdata_q;

    // ------------------------------------------------------------
    // Operation controls to the array
    // ------------------------------------------------------------

    // Overlay blocks program and erase but keeps the verify modes.
    // No one-hot guard: software keeps to one select bit, and its
    // watchdog, not this block, limits how long P or E stays set.
    assign PROGRAM_EN = mode_sel_q[FMC_BIT_PROG] && !overlay_one;
    assign ERASE_EN = mode_sel_q[FMC_BIT_ERASE] && !overlay_one;
    assign PROGRAM_VERIFY_EN = mode_sel_q[FMC_BIT_PROG_VERIFY];
    assign ERASE_VERIFY_EN = mode_sel_q[FMC_BIT_ERASE_VERIFY];
    assign LARGE_BLOCK_EN = large_sel_q;
    assign SMALL_BLOCK_EN = small_sel_q;

    // ------------------------------------------------------------
    // Boot serial pins
    // ------------------------------------------------------------

    // Pins pass to the serial channel; rate matching lives there.
    // No retiming here, so whatever rate the channel matches passes.
    assign BOOT_SERIAL_OUT = BOOT_TX_DATA;
    assign BOOT_RX_DATA = BOOT_SERIAL_IN;
endmodule
`default_nettype wire

// >>> test/fmc_flash_model.sv
// Flash array model: answers word reads from a fixed address pattern
`timescale 1ns/10ps
`default_nettype none
module fmc_flash_model
#(
    parameter int AW = 15
)
(
    // Array port
    input wire logic [AW-1:0] addr,
    input wire logic en,
    output logic [15:0] data
);
    // Pattern from the word address; inverted while idle so stale data shows
    always_comb
    begin
        data = 16'(addr) ^ {addr[7:0], 8'h00} ^ 16'h5ac3;
        if (!en)
            data = ~data;
    end
endmodule
`default_nettype wire

// >>> test/fmc_top_sva.sv
// Checker: port-level properties of the flash mode control unit
`timescale 1ns/10ps
`default_nettype none
module fmc_top_sva
    import fmc_pkg::*;
(
    // Clock, reset, pins and bus
    input wire logic CLK, input wire logic SRST,
    input wire logic MODE_PIN_HIGH, input wire logic MODE_PIN_LOW,
    input wire logic PROGRAMMING_SUPPLY_INPUT, input wire logic BUS_REQ,
    input wire logic [15:0] BUS_ADDR, input wire logic BUS_ACK,
    input wire logic BUS_EXTERNAL, input wire logic ARRAY_EN,
    // Operation controls
    input wire logic PROGRAM_EN, input wire logic ERASE_EN,
    input wire logic PROGRAM_VERIFY_EN, input wire logic ERASE_VERIFY_EN,
    input wire logic [7:0] LARGE_BLOCK_EN,
    input wire logic [7:0] SMALL_BLOCK_EN,
    input wire logic RAM_OVERLAY_ACTIVE, input wire fmc_mode_t OPERATING_MODE,
    input wire logic MODE_ILLEGAL, input wire logic BOOT_SERIAL_IN,
    input wire logic BOOT_SERIAL_OUT, input wire logic BOOT_TX_DATA,
    input wire logic BOOT_RX_DATA
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic ctrl_hit;
    logic [3:0] ops;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);
    // Request aimed at the supply-gated register window
    assign ctrl_hit = BUS_REQ && BUS_ADDR >= FMC_CTRL_LO &&
                      BUS_ADDR <= FMC_CTRL_HI;
    assign ops = {ERASE_VERIFY_EN, PROGRAM_VERIFY_EN, ERASE_EN, PROGRAM_EN};

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_read_two_states: assert property ($rose(ARRAY_EN) |=> BUS_ACK)
        else $error("flash read not answered in two states");
    a_array_single: assert property (ARRAY_EN |=> !ARRAY_EN)
        else $error("array enable longer than one state");
    a_ack_single: assert property (BUS_ACK |=> !BUS_ACK)
        else $error("bus acknowledge longer than one cycle");
    a_mode_decode: assert property (OPERATING_MODE ==
        fmc_mode_t'({MODE_PIN_HIGH, MODE_PIN_LOW}) &&
        MODE_ILLEGAL == !(MODE_PIN_HIGH || MODE_PIN_LOW))
        else $error("mode pins decoded wrongly");
    a_ops_no_supply: assert property (!PROGRAMMING_SUPPLY_INPUT [*2]
        |-> ops == 4'h0)
        else $error("mode bits kept without supply");
    a_blocks_no_supply: assert property (!PROGRAMMING_SUPPLY_INPUT [*2]
        |-> LARGE_BLOCK_EN == 8'h00 && SMALL_BLOCK_EN == 8'h00)
        else $error("block selects kept without supply");
    a_route_external: assert property (ctrl_hit && !PROGRAMMING_SUPPLY_INPUT &&
        OPERATING_MODE == FMC_MODE_ROM2 |-> BUS_EXTERNAL ##1 !BUS_ACK)
        else $error("control window not routed off chip");
    a_overlay_guard: assert property (RAM_OVERLAY_ACTIVE
        |-> !PROGRAM_EN && !ERASE_EN)
        else $error("program or erase during overlay");
    a_boot_wires: assert property (BOOT_SERIAL_OUT == BOOT_TX_DATA &&
        BOOT_RX_DATA == BOOT_SERIAL_IN)
        else $error("boot serial pins not passed through");

    // Main scenarios reached
    c_flash_read: cover property ($rose(ARRAY_EN) ##1 BUS_ACK);
    c_external: cover property (ctrl_hit && BUS_EXTERNAL);
    c_overlay: cover property (RAM_OVERLAY_ACTIVE && PROGRAM_VERIFY_EN);
    c_program: cover property (PROGRAM_EN);
endmodule

bind fmc_top fmc_top_sva fmc_top_sva_inst (.CLK(CLK), .SRST(SRST),
    .MODE_PIN_HIGH(MODE_PIN_HIGH), .MODE_PIN_LOW(MODE_PIN_LOW),
    .PROGRAMMING_SUPPLY_INPUT(PROGRAMMING_SUPPLY_INPUT), .BUS_REQ(BUS_REQ),
    .BUS_ADDR(BUS_ADDR), .BUS_ACK(BUS_ACK), .BUS_EXTERNAL(BUS_EXTERNAL),
    .ARRAY_EN(ARRAY_EN), .PROGRAM_EN(PROGRAM_EN), .ERASE_EN(ERASE_EN),
    .PROGRAM_VERIFY_EN(PROGRAM_VERIFY_EN), .ERASE_VERIFY_EN(ERASE_VERIFY_EN),
    .LARGE_BLOCK_EN(LARGE_BLOCK_EN), .SMALL_BLOCK_EN(SMALL_BLOCK_EN),
    .RAM_OVERLAY_ACTIVE(RAM_OVERLAY_ACTIVE), .OPERATING_MODE(OPERATING_MODE),
    .MODE_ILLEGAL(MODE_ILLEGAL), .BOOT_SERIAL_IN(BOOT_SERIAL_IN),
    .BOOT_SERIAL_OUT(BOOT_SERIAL_OUT), .BOOT_TX_DATA(BOOT_TX_DATA),
    .BOOT_RX_DATA(BOOT_RX_DATA));
`default_nettype wire

// >>> test/test_flash_mode_control_unit.sv
// Testbench: self-checking run of the flash mode control unit
`timescale 1ns/10ps
`default_nettype none
module test_flash_mode_control_unit;
    import fmc_pkg::*;
    logic clk, srst, stby, mh, ml, vpp, req, wr, byt, sin, txd, ext_seen;
    logic ack, ext, pe, ee, pve, eve, ovl, illg, sout, rxd, aen;
    logic [15:0] addr, wdat, rdat, adat, rcap;
    logic [14:0] aadr;
    logic [7:0] lbe, sbe;
    fmc_mode_t opm;
    int failures, compares;

    // ------------------------------------------------------------
    // Design and array model
    // ------------------------------------------------------------
    fmc_top #(.FLASH_AW(15)) fmc_top_inst (.CLK(clk), .SRST(srst),
        .STANDBY(stby), .MODE_PIN_HIGH(mh), .MODE_PIN_LOW(ml),
        .PROGRAMMING_SUPPLY_INPUT(vpp), .BUS_REQ(req), .BUS_WR(wr),
        .BUS_BYTE(byt), .BUS_ADDR(addr), .BUS_WDATA(wdat), .BUS_RDATA(rdat),
        .BUS_ACK(ack), .BUS_EXTERNAL(ext), .ARRAY_ADDR(aadr), .ARRAY_EN(aen),
        .ARRAY_DATA(adat), .PROGRAM_EN(pe), .ERASE_EN(ee),
        .PROGRAM_VERIFY_EN(pve), .ERASE_VERIFY_EN(eve), .LARGE_BLOCK_EN(lbe),
        .SMALL_BLOCK_EN(sbe), .RAM_OVERLAY_ACTIVE(ovl), .OPERATING_MODE(opm),
        .MODE_ILLEGAL(illg), .BOOT_SERIAL_IN(sin), .BOOT_SERIAL_OUT(sout),
        .BOOT_TX_DATA(txd), .BOOT_RX_DATA(rxd));
    fmc_flash_model #(.AW(15)) fmc_flash_model_inst (.addr(aadr), .en(aen),
        .data(adat));

    // 40 MHz clock
    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Expectations, compare and bus tasks
    // ------------------------------------------------------------
    function automatic logic [15:0] fdat(input logic [15:0] a);
        return {1'b0, a[15:1]} ^ {a[8:1], 8'h00} ^ 16'h5ac3;
    endfunction
    function automatic logic [15:0] dup(input logic [7:0] v);
        return {v, v};
    endfunction
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask
    // Request held through the edge that samples acknowledge
    task automatic bus(input logic w, input logic b, input logic [15:0] a,
                       input logic [15:0] d, output logic k);
        int n;
        n = 0;
        k = 0;
        @(posedge clk);
        {req, wr, byt, addr, wdat} <= {1'b1, w, b, a, d};
        while (!k && n < 8)
        begin
            @(posedge clk);
            #1;
            n++;
            ext_seen = ext;
            rcap = rdat;
            k = (ack === 1'b1);
        end
        @(posedge clk);
        req <= 0;
    endtask
    task automatic rd(input logic b, input logic [15:0] a,
                      input logic [15:0] exp, input string what);
        logic k;
        bus(0, b, a, 16'h0000, k);
        cmp({15'h0000, k}, 16'h0001, what);
        cmp(rcap, exp, what);
    endtask
    task automatic wr_reg(input logic b, input logic [15:0] a,
                          input logic [15:0] d);
        logic k;
        bus(1, b, a, d, k);
        cmp({15'h0000, k}, 16'h0001, "write ack");
    endtask
    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog far beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [15:0] w, top, a;
        logic [7:0] v;
        logic k;
        {srst, mh, ml, vpp} = 4'hf;
        {stby, req, wr, byt, sin, txd, addr, wdat} = '0;
        void'($urandom(21664));
        repeat (5) @(posedge clk);
        srst <= 0;
        rd(1, FMC_ADDR_MODE_CTRL, dup(FMC_RST_MODE_CTRL_VPP), "mode rst");
        rd(1, FMC_ADDR_LARGE_SEL, 16'h0000, "large rst");
        rd(1, FMC_ADDR_SMALL_SEL, 16'h0000, "small rst");
        rd(1, FMC_ADDR_WAIT_OVL, dup(FMC_RST_WAIT_OVL), "wait rst");
        $display("test reset values done");
        // Each mode bit alone; reserved and status bits written against
        for (int i = 0; i < 4; i++)
        begin
            v = 8'h01 << i;
            wr_reg(1, FMC_ADDR_MODE_CTRL, {8'h70 | v, 8'h00});
            rd(1, FMC_ADDR_MODE_CTRL, dup(8'h80 | v), "mode bit");
            cmp({12'h000, eve, pve, ee, pe}, {8'h00, v}, "ops");
        end
        $display("test mode bits done");
        repeat (4)
        begin
            w = 16'($urandom);
            wr_reg(0, FMC_ADDR_LARGE_SEL, w);
            rd(1, FMC_ADDR_LARGE_SEL, dup(w[15:8]), "large");
            rd(1, FMC_ADDR_SMALL_SEL, dup(w[7:0]), "small");
        end
        wr_reg(1, FMC_ADDR_SMALL_SEL, 16'h00ff);
        cmp({lbe, sbe}, {w[15:8], 8'hff}, "block enables");
        $display("test block selects done");
        // Supply removed in mode 3: window reads ff, state cleared
        @(posedge clk);
        vpp <= 0;
        rd(1, FMC_ADDR_MODE_CTRL, 16'hffff, "no supply");
        wr_reg(1, FMC_ADDR_LARGE_SEL, 16'h5500);
        rd(1, FMC_ADDR_LARGE_SEL, 16'hffff, "no supply large");
        cmp({lbe, sbe}, 16'h0000, "cleared blocks");
        cmp({12'h000, eve, pve, ee, pe}, 16'h0000, "cleared ops");
        @(posedge clk);
        vpp <= 1;
        rd(1, FMC_ADDR_MODE_CTRL, dup(8'h80), "supply back");
        $display("test supply removal done");
        // Mode 2 without supply: window and top gap go off chip
        @(posedge clk);
        {mh, ml, vpp} <= 3'b100;
        bus(0, 1, FMC_ADDR_SMALL_SEL, 16'h0000, k);
        cmp({14'h0, k, ext_seen}, 16'h0001, "external window");
        bus(0, 0, FMC_TOP_MODE2 + 16'h0001, 16'h0000, k);
        cmp({14'h0, k, ext_seen}, 16'h0001, "above flash");
        for (int m = 2; m < 4; m++)
        begin
            @(posedge clk);
            {mh, ml} <= 2'(m);
            top = (m == 2) ? FMC_TOP_MODE2 : FMC_TOP_MODE3;
            for (int j = 0; j < 6; j++)
            begin
                a = (j == 0) ? top : 16'($urandom_range(int'(top)));
                rd(1'($urandom_range(1)), a, fdat(a), "flash");
            end
        end
        $display("test flash reads done");
        @(posedge clk);
        {mh, ml, vpp} <= 3'b011;
        wr_reg(1, FMC_ADDR_MODE_CTRL, 16'h0100);
        rd(1, FMC_ADDR_MODE_CTRL, 16'hffff, "mode 1");
        cmp({12'h000, eve, pve, ee, pe}, 16'h0000, "mode 1 ops");
        $display("test mode 1 done");
        // One overlay bit blocks program but not verify
        @(posedge clk);
        {mh, ml} <= 2'b11;
        wr_reg(1, FMC_ADDR_WAIT_OVL, 16'h4800);
        wr_reg(1, FMC_ADDR_MODE_CTRL, 16'h0100);
        cmp({14'h0, ovl, pe}, 16'h0002, "overlay program");
        wr_reg(1, FMC_ADDR_MODE_CTRL, 16'h0400);
        cmp({15'h0, pve}, 16'h0001, "overlay verify");
        wr_reg(1, FMC_ADDR_WAIT_OVL, 16'hc800);
        wr_reg(1, FMC_ADDR_MODE_CTRL, 16'h0100);
        cmp({14'h0, ovl, pe}, 16'h0001, "both overlay bits");
        @(posedge clk);
        stby <= 1;
        @(posedge clk);
        stby <= 0;
        rd(1, FMC_ADDR_MODE_CTRL, dup(8'h80), "standby");
        $display("test overlay and standby done");
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            {mh, ml, sin, txd} <= 4'($urandom);
            @(negedge clk);
            cmp(16'({opm, illg, sout, rxd}),
                16'({mh, ml, !(mh | ml), txd, sin}), "pins");
        end
        $display("test pins done");
        test_done();
    end
endmodule
`default_nettype wire
